// ---- hw/lca_defines.svh ----
`ifndef LCA_DEFINES_SVH
`define LCA_DEFINES_SVH

// register offsets on the serial register port
`define LCA_ADDR_RESULT 8'h00
`define LCA_ADDR_CONTROL 8'h01
// operating_control field positions
`define LCA_RANGE_MSB 15
`define LCA_RANGE_LSB 12
`define LCA_CT_BIT 11
`define LCA_MODE_MSB 10
`define LCA_MODE_LSB 9
`define LCA_OVF_BIT 8
`define LCA_DONE_BIT 7
`define LCA_ABOVE_BIT 6
`define LCA_BELOW_BIT 5
// reset values
`define LCA_CONTROL_RESET 16'hC810
`define LCA_RESULT_RESET 16'h0000
// range codes
`define LCA_RANGE_AUTO 4'hC
`define LCA_RANGE_MAX 4'hB
`define LCA_RANGE_ONE_BIT 4'h5
`define LCA_RANGE_THREE_BIT 4'h0
// mode codes
`define LCA_MODE_SHUTDOWN 2'h0
`define LCA_MODE_SINGLE 2'h1
// conversion times
`define LCA_CLOCK_MHZ 250
`define LCA_CONV_SHORT_MS 100
`define LCA_CONV_LONG_MS 800
`define LCA_CONV_SHORT_CYCLES (`LCA_CONV_SHORT_MS * 1000 * `LCA_CLOCK_MHZ)
`define LCA_CONV_LONG_CYCLES (`LCA_CONV_LONG_MS * 1000 * `LCA_CLOCK_MHZ)

`endif

// ---- hw/lca_pkg.sv ----
package lca_pkg;

    typedef struct packed {
        logic [3:0] range_select;
        logic conversion_time_select;
        logic [1:0] mode;
        logic overrange_flag;
        logic conversion_done_flag;
        logic above_limit_flag;
        logic below_limit_flag;
        logic latch;
        logic polarity;
        logic mask_exponent;
        logic [1:0] fault_tally_select;
    } lca_control_t;

    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } lca_result_t;

    typedef enum logic [1:0] {
        LCA_IDLE = 2'b00,
        LCA_CONVERT = 2'b01
    } lca_state_t;

endpackage

// ---- hw/lca_fault_tally.sv ----
`timescale 1ns/10ps
module lca_fault_tally
    import lca_pkg::*;
#(
    parameter int TALLY_WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // measurement events
    input wire logic sample,
    input wire logic hit,
    input wire logic [TALLY_WIDTH-1:0] needed,
    // flag
    output logic flag
);
    if (TALLY_WIDTH < 4) begin
        $error("tally width too small for count of eight");
    end

    logic [TALLY_WIDTH-1:0] tally;
    wire [TALLY_WIDTH-1:0] next_tally = hit ? ((tally == needed) ? tally : tally + 1'b1)
                                            : '0;

    always_ff @(posedge clock) begin
        if (reset) begin
            tally <= '0;
            flag <= 1'b0;
        end else if (sample) begin
            tally <= next_tally;
            flag <= (next_tally == needed);
        end
    end
endmodule

// ---- hw/lca_converter_control.sv ----
`timescale 1ns/10ps
`include "lca_defines.svh"
// Notes on behaviour
// R1 - conversion lasts 100 ms with time bit 0, 800 ms with 1; resets to 1
// R2 - short time drops low result bits: range 5 one, 1-4 two, 0 three
// R3 - result format and bit weight do not depend on conversion time
// R4 - mode 00 shutdown, 01 single shot, 10 and 11 continuous
// R5 - mode field resets to 00, so device idles in shutdown
// R6 - single shot reads 01 while running, then clears itself to 00
// R7 - entering shutdown leaves done flag, limit flags and alert untouched
// R8 - overrange flag set on overload, cleared otherwise, every measurement
// R9 - fixed range: transient overload may set overrange with in-range result
// R10 - auto range: overrange only beyond the highest range full scale
// R11 - auto range: overload steps range up and restarts, flag updated afterward
// R12 - done flag set at the end of every conversion
// R13 - control read clears done flag; writes clear it unless mode written 00
// R14 - above flag when result exceeds high limit for the selected tally
// R15 - below flag when result under low limit for the selected tally
// R16 - range 1100 selects auto ranging; 1101-1111 reserved; resets to 1100
// R17 - control write aborts a running conversion, restarts if mode converts
// R18 - tally code 00 needs one measurement; others need two, four, eight
// R19 - continuous mode starts the next conversion right after each ends
module lca_converter_control
    import lca_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = `LCA_CONV_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES = `LCA_CONV_LONG_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // decoded register accesses from the serial port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // threshold limits held outside
    input wire logic [15:0] low_limit,
    input wire logic [15:0] high_limit,
    // analog converter front end
    input wire logic [11:0] adc_code,
    input wire logic adc_overload,
    output logic adc_active,
    output logic [3:0] adc_range,
    // results
    output lca_result_t result,
    output logic alert
);
    // parameter checks at elaboration
    if (SHORT_CYCLES < 1) begin
        $error("short conversion needs at least one cycle");
    end
    if (LONG_CYCLES < SHORT_CYCLES || LONG_CYCLES > 32'h7FFFFFFF) begin
        $error("long conversion cycle count out of range");
    end

    // linear value of an exponent and mantissa pair
    function automatic logic [26:0] to_linear(input logic [15:0] word);
        to_linear = 27'(word[11:0]) << word[15:12];
    endfunction

    lca_control_t ctrl;
    lca_state_t state;
    logic [31:0] elapsed;
    logic above_flag;
    logic below_flag;

    // register access decode
    wire ctrl_hit = (reg_addr == `LCA_ADDR_CONTROL);
    wire ctrl_write = reg_write && ctrl_hit;
    wire ctrl_read = reg_read && ctrl_hit;
    wire [1:0] wr_mode = reg_wdata[`LCA_MODE_MSB:`LCA_MODE_LSB];
    wire wants_convert = (wr_mode != `LCA_MODE_SHUTDOWN);
    wire auto_range = (ctrl.range_select == `LCA_RANGE_AUTO); // R16

    // conversion timing
    wire [31:0] conv_cycles = ctrl.conversion_time_select ? 32'(LONG_CYCLES)
                                                        : 32'(SHORT_CYCLES); // R1
    wire converting = (state == LCA_CONVERT);
    wire step_up = converting && auto_range && adc_overload
                   && (adc_range != `LCA_RANGE_MAX); // R11
    // a control write in the last cycle aborts instead of finishing
    wire conv_end = converting && !step_up && !ctrl_write && (elapsed == conv_cycles - 32'd1);
    wire keep_going = ctrl.mode[1]; // R4 R19

    // resolution trim on the short conversion time
    wire [1:0] drop_bits = ctrl.conversion_time_select ? 2'd0 :
                           (adc_range == `LCA_RANGE_ONE_BIT) ? 2'd1 :
                           (adc_range == `LCA_RANGE_THREE_BIT) ? 2'd3 :
                           (adc_range < `LCA_RANGE_ONE_BIT) ? 2'd2 : 2'd0; // R2
    wire [11:0] trim_mask = 12'hFFF << drop_bits;
    // same exponent and mantissa layout for either time
    wire [15:0] next_result = {adc_range, adc_code & trim_mask}; // R3
    wire [26:0] next_linear = to_linear(next_result);
    wire above_hit = next_linear > to_linear(high_limit); // R14
    wire below_hit = next_linear < to_linear(low_limit); // R15
    // overload anywhere in the running conversion; auto steps restart the record
    // so a passing spike on a fixed range still raises the flag
    logic overload_seen;
    wire next_overrange = overload_seen || adc_overload; // R8 R9 R10
    wire [3:0] tally_needed = 4'h1 << ctrl.fault_tally_select; // R18

    always_ff @(posedge clock) begin
        if (reset || ctrl_write || step_up || conv_end || !converting) begin
            overload_seen <= 1'b0;
        end else begin
            overload_seen <= overload_seen || adc_overload; // R9 R10
        end
    end

    // done flag: set wins over any clear
    wire done_clear = ctrl_read || (ctrl_write && wants_convert); // R13
    wire next_done = conv_end ? 1'b1 : (done_clear ? 1'b0 : ctrl.conversion_done_flag); // R12

    wire [15:0] ctrl_word = {ctrl.range_select, ctrl.conversion_time_select, ctrl.mode,
                             ctrl.overrange_flag, ctrl.conversion_done_flag, above_flag,
                             below_flag, ctrl.latch, ctrl.polarity, ctrl.mask_exponent,
                             ctrl.fault_tally_select};
    wire [15:0] next_rdata = ctrl_hit ? ctrl_word :
                             (reg_addr == `LCA_ADDR_RESULT) ? result : 16'h0000;

    // converter sequencing
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= LCA_IDLE;
            elapsed <= 32'd0;
            adc_range <= 4'h0;
        end else if (ctrl_write) begin
            state <= wants_convert ? LCA_CONVERT : LCA_IDLE; // R17
            elapsed <= 32'd0;
            adc_range <= (reg_wdata[15:12] == `LCA_RANGE_AUTO) ? 4'h0 : reg_wdata[15:12];
        end else begin
            case (state)
                LCA_IDLE: begin
                    elapsed <= 32'd0;
                end
                LCA_CONVERT: begin
                    if (step_up) begin
                        adc_range <= adc_range + 4'h1; // R11
                        elapsed <= 32'd0;
                    end else if (conv_end) begin
                        elapsed <= 32'd0;
                        state <= keep_going ? LCA_CONVERT : LCA_IDLE; // R6 R19
                        if (auto_range) begin
                            adc_range <= 4'h0;
                        end
                    end else begin
                        elapsed <= elapsed + 32'd1;
                    end
                end
                default: begin
                    state <= LCA_IDLE;
                end
            endcase
        end
    end

    // control register
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl <= lca_control_t'(`LCA_CONTROL_RESET); // R1 R5 R16
        end else begin
            ctrl.conversion_done_flag <= next_done;
            if (ctrl_write) begin
                ctrl.range_select <= reg_wdata[15:12];
                ctrl.conversion_time_select <= reg_wdata[`LCA_CT_BIT];
                ctrl.mode <= wr_mode; // R4
                ctrl.latch <= reg_wdata[4];
                ctrl.polarity <= reg_wdata[3];
                ctrl.mask_exponent <= reg_wdata[2];
                ctrl.fault_tally_select <= reg_wdata[1:0];
            end else if (conv_end) begin
                ctrl.overrange_flag <= next_overrange; // R8 R11
                if (ctrl.mode == `LCA_MODE_SINGLE) begin
                    ctrl.mode <= `LCA_MODE_SHUTDOWN; // R6
                end
            end
        end
    end

    // result, alert and bus read data; shutdown leaves flags alone
    always_ff @(posedge clock) begin
        if (reset) begin
            result <= lca_result_t'(`LCA_RESULT_RESET);
            alert <= 1'b0;
            reg_rdata <= 16'h0000;
            adc_active <= 1'b0;
        end else begin
            if (conv_end) begin
                result <= next_result;
            end
            alert <= above_flag || below_flag; // R7
            adc_active <= ctrl_write ? wants_convert : (conv_end ? keep_going : converting);
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    lca_fault_tally #(
        .TALLY_WIDTH(4)
    ) u_above (
        .clock(clock),
        .reset(reset),
        .sample(conv_end),
        .hit(above_hit),
        .needed(tally_needed),
        .flag(above_flag)
    ); // R14 R18

    lca_fault_tally #(
        .TALLY_WIDTH(4)
    ) u_below (
        .clock(clock),
        .reset(reset),
        .sample(conv_end),
        .hit(below_hit),
        .needed(tally_needed),
        .flag(below_flag)
    ); // R15 R18
endmodule

// ---- verification/lca_checker.sv ----
`timescale 1ns/10ps
module lca_checker #(
    parameter int unsigned SHORT_CYCLES = 20,
    parameter int unsigned LONG_CYCLES = 40
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register access
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // converter and alert
    input wire logic adc_active,
    input wire logic [3:0] adc_range,
    input wire logic adc_overload,
    input wire logic alert
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [3:0] rng_w;
    logic ct_w;
    logic [1:0] mode_w;
    int unsigned cnt;
    wire logic ctl_wr = reg_write && reg_addr == 8'h01;
    // shadow of the last written range, time and mode
    always_ff @(posedge clock) begin
        if (reset) begin
            {rng_w, ct_w, mode_w} <= 7'h64;
        end else if (ctl_wr) begin
            {rng_w, ct_w, mode_w} <= reg_wdata[15:9];
        end
    end
    always_ff @(posedge clock) begin
        if (reset || ctl_wr || !adc_active) begin
            cnt <= (adc_active && !ctl_wr && !reset) ? 1 : 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    idle_stays_a: assert property (!adc_active && !reg_write |=> !adc_active)
        else $error("conversion started without a write");
    stop_write_a: assert property (ctl_wr && reg_wdata[10:9] == 2'h0 |=> !adc_active)
        else $error("shutdown write left converter running");
    fixed_start_a: assert property (ctl_wr && reg_wdata[10:9] != 2'h0 && reg_wdata[15:12] != 4'hC
        |=> adc_active && adc_range == rng_w)
        else $error("fixed range conversion did not start");
    auto_start_a: assert property (ctl_wr && reg_wdata[10:9] != 2'h0 && reg_wdata[15:12] == 4'hC
        |=> adc_active && adc_range == 4'h0)
        else $error("auto range did not start at range 0");
    auto_step_a: assert property (adc_active && rng_w == 4'hC && adc_overload && adc_range < 4'hB
        && !reg_write |=> adc_range == $past(adc_range) + 4'h1)
        else $error("auto range did not step up");
    fixed_hold_a: assert property (adc_active && rng_w != 4'hC && !reg_write |=> $stable(adc_range))
        else $error("fixed range changed");
    conv_len_a: assert property ($fell(adc_active) && !$past(reg_write) && rng_w != 4'hC
        |-> cnt == (ct_w ? LONG_CYCLES : SHORT_CYCLES))
        else $error("conversion length wrong");
    single_end_a: assert property ($fell(adc_active) && !$past(reg_write) |-> mode_w == 2'h1)
        else $error("conversion stopped outside single shot");
    cont_run_a: assert property (adc_active && mode_w[1] && !reg_write |=> adc_active)
        else $error("continuous mode stopped");
    alert_hold_a: assert property (!adc_active && !$past(adc_active) && !$past(adc_active, 2)
        && !$past(adc_active, 3) |-> $stable(alert))
        else $error("alert changed while shut down");
endmodule
bind lca_converter_control lca_checker #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES))
    u_checker (.clock(clock), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .adc_active(adc_active), .adc_range(adc_range),
    .adc_overload(adc_overload), .alert(alert));

// ---- verification/lca_adc_model.sv ----
`timescale 1ns/10ps
module lca_adc_model (
    // clock
    input wire logic clock,
    // converter control
    input wire logic adc_active,
    input wire logic [3:0] adc_range,
    // light level and forced overload
    input wire logic [23:0] light,
    input wire logic spike,
    // converter outputs
    output logic [11:0] adc_code,
    output logic adc_overload
);
    wire logic [23:0] scaled = light >> adc_range;
    assign adc_overload = adc_active && (spike || scaled > 24'h000FFF);
    // code toggles while idle so stale values never look valid
    always_ff @(posedge clock) begin
        if (adc_active) begin
            adc_code <= (scaled > 24'h000FFF) ? 12'hFFF : scaled[11:0];
        end else begin
            adc_code <= ~adc_code;
        end
    end
endmodule

// ---- verification/lca_converter_control_test.sv ----
`timescale 1ns/10ps
module lca_converter_control_test;
    import lca_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] low_limit = 16'h0000;
    logic [15:0] high_limit = 16'hFFFF;
    logic [11:0] adc_code;
    logic adc_overload;
    logic adc_active;
    logic [3:0] adc_range;
    lca_result_t result;
    logic alert;
    logic [23:0] light = 24'h000000;
    logic spike = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    lca_converter_control #(.SHORT_CYCLES(20), .LONG_CYCLES(40)) DUT (
        .clock(clock), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .low_limit(low_limit), .high_limit(high_limit), .adc_code(adc_code),
        .adc_overload(adc_overload), .adc_active(adc_active), .adc_range(adc_range),
        .result(result), .alert(alert));
    lca_adc_model u_adc (.clock(clock), .adc_active(adc_active), .adc_range(adc_range),
        .light(light), .spike(spike), .adc_code(adc_code), .adc_overload(adc_overload));
    always #2 clock = ~clock;
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= 8'h01;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        chk(reg_rdata & m, e);
    endtask
    task automatic wait_end();
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        while (adc_active !== 1'b0 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        chk({15'h0000, adc_active}, 16'h0000);
        repeat (3) @(posedge clock);
    endtask
    task automatic t_reset();
        rdc(8'h01, 16'hFFFF, 16'hC810);
        rdc(8'h00, 16'hFFFF, 16'h0000);
        rdc(8'h07, 16'hFFFF, 16'h0000);
        chk({15'h0000, alert}, 16'h0000);
        $display("reset test done");
    endtask
    task automatic tc(input logic [15:0] w, input logic [23:0] lt, input logic sp,
            input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] res,
            input logic [15:0] ctl, input logic al);
        @(posedge clock);
        light <= lt;
        spike <= sp;
        low_limit <= lo;
        high_limit <= hi;
        wr(w);
        rdc(8'h01, 16'h0600, 16'h0200);
        wait_end();
        chk(result, res);
        rdc(8'h01, 16'hFFFF, ctl);
        rdc(8'h01, 16'hFFFF, ctl & 16'hFF7F);
        chk({15'h0000, alert}, {15'h0000, al});
        $display("conversion test done %h", w);
    endtask
    task automatic t_cont();
        @(posedge clock);
        light <= 24'h000ABF;
        low_limit <= 16'hFFFF;
        wr(16'h5C00);
        repeat (100) @(posedge clock);
        rdc(8'h01, 16'hFFFF, 16'h5CA0);
        chk(result, 16'h5055);
        wr(16'h5C00);
        rdc(8'h01, 16'hFFFF, 16'h5C20);
        repeat (45) @(posedge clock);
        wr(16'h5800);
        rdc(8'h01, 16'hFFFF, 16'h58A0);
        chk({15'h0000, alert}, 16'h0001);
        chk({15'h0000, adc_active}, 16'h0000);
        $display("continuous test done");
    endtask
    task automatic t_tally();
        @(posedge clock);
        light <= 24'h000800;
        spike <= 1'b0;
        low_limit <= 16'h0000;
        high_limit <= 16'h0000;
        wr(16'h7601);
        repeat (22) @(posedge clock);
        rdc(8'h01, 16'hFFFF, 16'h7681);
        chk({15'h0000, alert}, 16'h0000);
        repeat (20) @(posedge clock);
        rdc(8'h01, 16'hFFFF, 16'h76C1);
        chk(result, 16'h7010);
        chk({15'h0000, alert}, 16'h0001);
        wr(16'h7001);
        rdc(8'h01, 16'hFFFF, 16'h7041);
        $display("fault tally test done");
    endtask
    initial begin
        #40000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        tc(16'h3200, 24'hABF, 1'b0, 16'h0000, 16'h0000, 16'h3154, 16'h30C0, 1'b1);
        tc(16'h3A00, 24'hABF, 1'b0, 16'hFFFF, 16'hFFFF, 16'h3157, 16'h38A0, 1'b1);
        tc(16'hC200, 24'hABCDE, 1'b0, 16'h0000, 16'hFFFF, 16'h8ABC, 16'hC080, 1'b0);
        tc(16'hC200, 24'hFFFFFF, 1'b0, 16'h0000, 16'hFFFF, 16'hBFFF, 16'hC180, 1'b0);
        t_cont();
        tc(16'h2200, 24'h100, 1'b1, 16'h0000, 16'hFFFF, 16'h2040, 16'h2180, 1'b0);
        t_tally();
        report_and_stop();
    end
endmodule
